/* uad_pkg.sv */
package uad_pkg;

  // Reference clock
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  // Detection intervals in milliseconds, ID check count and counter widths
  localparam int SDP_MS = 120;
  localparam int CHG_MS = 160;
  localparam int CARKIT_MS = 140;
  localparam int ID_RES_MS = 50;
  localparam int ID_CHECKS = 3;
  localparam int DCD_MS = 600;
  localparam int DCD_MIN_MS = 300;
  localparam int DCD_MAX_MS = 900;
  localparam int I2C_RST_MS = 30;
  localparam int MS_W = 10;
  localparam int LOW_W = 6;

  // Spike suppression; shortest glitch-free hold rounds up
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;

  // Serial slave
  localparam logic [6:0] I2C_ADDR = 7'h25;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h9;
  localparam logic [3:0] BIT_MSB = 4'h7;

  // Synchroniser lanes
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_VBUS = 2;
  localparam int SYN_ID = 3;
  localparam int SYN_CONTACT = 4;
  localparam int SYN_SDP = 5;
  localparam int SYN_CDP = 6;
  localparam int SYN_DCP = 7;
  localparam int SYN_CAR = 8;
  localparam int SYN_W = 9;
  localparam logic [8:0] SYN_RST = 9'h003;

  // Detected type bits
  localparam int DT_SDP = 0;
  localparam int DT_CDP = 1;
  localparam int DT_DCP = 2;
  localparam int DT_CAR = 3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_BC = 5'h02,
    ST_BC_DONE = 5'h04,
    ST_ID = 5'h08,
    ST_ID_DONE = 5'h10
  } uad_state_type;

endpackage : uad_pkg

/* uad_sync.sv */
`timescale 1ns/1ns
module uad_sync #(
  parameter int W = 1,
  parameter int STABLE = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] filt_o
);

  localparam int CW = $clog2(STABLE + 1);

  if (STABLE < 1)
  begin : g_chk
    $error("uad_sync: STABLE must be at least one");
  end

  // One three-stage synchroniser and hold filter per lane
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
      logic [CW-1:0] cnt;
    } uad_sync_state_type;

    uad_sync_state_type q;
    uad_sync_state_type next_q;

    // A change counts only after stages two and three agree for STABLE cycles
    always_comb
    begin
      next_q = q;
      next_q.s1 = async_i[i];
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      if (q.s2 == q.s3 && q.s3 != q.out)
      begin
        if (q.cnt == CW'(STABLE - 1))
        begin
          next_q.out = q.s3;
          next_q.cnt = '0;
        end
        else
        begin
          next_q.cnt = q.cnt + 1'b1;
        end
      end
      else
      begin
        next_q.cnt = '0; // Glitch shorter than the hold is dropped
      end
    end

    // Stages start at the idle level so reset release gives no false edge
    always_ff @(posedge mclk_i)
    begin
      if (rst_i)
        q <= '{s1: RST_VAL[i], s2: RST_VAL[i], s3: RST_VAL[i], out: RST_VAL[i], cnt: '0};
      else
        q <= next_q;
    end

    assign filt_o[i] = q.out;

    property p_spike;
      @(posedge mclk_i) disable iff (rst_i)
      (q.out != $past(q.out)) |-> ($past(q.cnt) == CW'(STABLE - 1)) && ($past(q.s3) == q.out);
    endproperty
    a_spike: assert property (p_spike) else $error("filter output changed too early");
  end

endmodule : uad_sync

/* uad_core.sv */
`timescale 1ns/1ns
module uad_core #(
  parameter int CYC_PER_MS = uad_pkg::CYC_PER_MS,
  parameter int DCD_MS = uad_pkg::DCD_MS,
  parameter int RES_MS = uad_pkg::ID_RES_MS,
  parameter int ID_CHECKS = uad_pkg::ID_CHECKS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic bus_power_in_i,
  input wire logic accessory_id_pin_i,
  input wire logic data_contact_i,
  input wire logic port_sdp_i,
  input wire logic port_cdp_i,
  input wire logic port_dcp_i,
  input wire logic carkit_i,
  input wire logic contact_timeout_enable_i,
  input wire logic manual_switch_select_i,
  input wire logic manual_fet_i,
  input wire logic manual_usb_i,
  output logic fet_close_o,
  output logic usb_switch_close_o,
  output logic irq_n_out_o,
  output logic [3:0] dev_type_o,
  output logic dcd_timeout_o,
  output logic i2c_reset_o,
  output logic sda_o,
  output logic sda_oe_o
);

  localparam int PRE_W = $clog2(CYC_PER_MS);
  localparam int MS_W = uad_pkg::MS_W;
  localparam int LOW_W = uad_pkg::LOW_W;

  if (CYC_PER_MS < 2 || DCD_MS < uad_pkg::DCD_MIN_MS || DCD_MS > uad_pkg::DCD_MAX_MS ||
      RES_MS < 1 || ID_CHECKS < 1 || ID_CHECKS > 4)
  begin : g_chk
    $error("uad_core: parameter out of range");
  end

  typedef struct packed {
    uad_pkg::uad_state_type st;
    logic [PRE_W-1:0] pre;
    logic [MS_W-1:0] ms;
    logic [LOW_W-1:0] lowms;
    logic lowhit;
    logic rstp;
    logic [1:0] idn;
    logic afet;
    logic ausb;
    logic fet;
    logic usb;
    logic irq_n;
    logic dcd_to;
    logic [3:0] dtype;
    logic scl_q;
    logic sda_q;
    logic act;
    logic addr_ph;
    logic rd;
    logic nack;
    logic sda_oe;
    logic sda_d;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] tx;
  } uad_core_state_type;

  localparam uad_core_state_type RST = '{st: uad_pkg::ST_IDLE, irq_n: 1'b1, scl_q: 1'b1,
                                          sda_q: 1'b1, default: '0};

  uad_core_state_type q;
  uad_core_state_type next_q;
  logic [uad_pkg::SYN_W-1:0] syn;
  logic tick;
  logic scl;
  logic sda;
  logic vbus;
  logic idat;
  logic [7:0] status;

  // Every detection and serial pin goes through the filter; the timeout enable and manual inputs do not
  uad_sync #(
    .W(uad_pkg::SYN_W),
    .STABLE(uad_pkg::SPIKE_CYC),
    .RST_VAL(uad_pkg::SYN_RST)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({carkit_i, port_dcp_i, port_cdp_i, port_sdp_i, data_contact_i,
              accessory_id_pin_i, bus_power_in_i, sda_i, scl_i}),
    .filt_o(syn)
  );

  assign scl = syn[uad_pkg::SYN_SCL];
  assign sda = syn[uad_pkg::SYN_SDA];
  assign vbus = syn[uad_pkg::SYN_VBUS];
  assign idat = syn[uad_pkg::SYN_ID];
  assign tick = (q.pre == PRE_W'(CYC_PER_MS - 1));
  assign status = {q.dcd_to, ~q.irq_n, vbus, idat, q.dtype};

  always_comb
  begin
    next_q = q;
    next_q.rstp = 1'b0;
    next_q.sda_d = 1'b0;
    // Millisecond prescaler; clearing it on an event only lengthens a count
    next_q.pre = tick ? '0 : q.pre + 1'b1;

    // Both serial lines low: counting whole milliseconds guarantees the full hold
    if (!scl && !sda)
    begin
      if (tick && !q.lowhit)
      begin
        if (q.lowms == LOW_W'(uad_pkg::I2C_RST_MS))
        begin
          next_q.lowhit = 1'b1;
          next_q.rstp = 1'b1;
        end
        else
        begin
          next_q.lowms = q.lowms + 1'b1;
        end
      end
    end
    else
    begin
      next_q.lowms = '0;
      next_q.lowhit = 1'b0;
    end

    // Detection sequencer
    case (q.st)
      uad_pkg::ST_IDLE:
      begin
        next_q.ms = '0;
        if (!idat)
          next_q.irq_n = 1'b1;
        if (vbus)
        begin
          next_q.st = uad_pkg::ST_BC;
          next_q.pre = '0;
        end
        else if (idat)
        begin
          next_q.st = uad_pkg::ST_ID;
          next_q.pre = '0;
          next_q.idn = '0;
        end
      end
      uad_pkg::ST_BC:
      begin
        if (!vbus)
        begin
          next_q.st = uad_pkg::ST_IDLE;
          next_q.afet = 1'b0;
          next_q.ausb = 1'b0;
          next_q.dtype = '0;
          next_q.dcd_to = 1'b0;
        end
        else if (tick)
        begin
          next_q.ms = q.ms + 1'b1;
          if (q.ms == MS_W'(uad_pkg::SDP_MS - 1) && syn[uad_pkg::SYN_SDP])
          begin
            next_q.afet = 1'b1;
            next_q.ausb = 1'b1;
            next_q.dtype[uad_pkg::DT_SDP] = 1'b1;
            next_q.st = uad_pkg::ST_BC_DONE;
          end
          else if (q.ms == MS_W'(uad_pkg::CARKIT_MS - 1) && syn[uad_pkg::SYN_CAR])
          begin
            next_q.dtype[uad_pkg::DT_CAR] = 1'b1;
            next_q.st = uad_pkg::ST_BC_DONE;
          end
          else if (q.ms == MS_W'(uad_pkg::CHG_MS - 1) &&
                   (syn[uad_pkg::SYN_CDP] || syn[uad_pkg::SYN_DCP]))
          begin
            // A dedicated port wins over a charging one and keeps USB open
            next_q.afet = 1'b1;
            next_q.ausb = !syn[uad_pkg::SYN_DCP];
            next_q.dtype[uad_pkg::DT_DCP] = syn[uad_pkg::SYN_DCP];
            next_q.dtype[uad_pkg::DT_CDP] = !syn[uad_pkg::SYN_DCP];
            next_q.st = uad_pkg::ST_BC_DONE;
          end
          else if (q.ms == MS_W'(DCD_MS - 1) && contact_timeout_enable_i &&
                   !syn[uad_pkg::SYN_CONTACT])
          begin
            next_q.dcd_to = 1'b1;
            next_q.st = uad_pkg::ST_BC_DONE;
          end
          else if (q.ms == '1)
          begin
            next_q.ms = q.ms; // Saturate while timeout is disabled or data contact was seen
          end
        end
      end
      uad_pkg::ST_BC_DONE:
      begin
        if (!vbus)
        begin
          next_q.st = uad_pkg::ST_IDLE;
          next_q.afet = 1'b0;
          next_q.ausb = 1'b0;
          next_q.dtype = '0;
          next_q.dcd_to = 1'b0;
        end
      end
      uad_pkg::ST_ID:
      begin
        if (vbus)
        begin
          next_q.st = uad_pkg::ST_BC;
          next_q.ms = '0;
          next_q.pre = '0;
        end
        else if (!idat)
        begin
          next_q.st = uad_pkg::ST_IDLE;
        end
        else if (tick)
        begin
          // One resistance check per interval, interrupt after the last
          if (q.ms == MS_W'(RES_MS - 1))
          begin
            next_q.ms = '0;
            if (q.idn == 2'(ID_CHECKS - 1))
            begin
              next_q.irq_n = 1'b0;
              next_q.st = uad_pkg::ST_ID_DONE;
            end
            else
            begin
              next_q.idn = q.idn + 1'b1;
            end
          end
          else
          begin
            next_q.ms = q.ms + 1'b1;
          end
        end
      end
      uad_pkg::ST_ID_DONE:
      begin
        if (!idat)
        begin
          next_q.irq_n = 1'b1;
          next_q.st = uad_pkg::ST_IDLE;
        end
        else if (vbus)
        begin
          next_q.st = uad_pkg::ST_BC;
          next_q.ms = '0;
          next_q.pre = '0;
        end
      end
      default:
      begin
        next_q.st = uad_pkg::ST_IDLE;
      end
    endcase

    // Serial slave: start, stop, then bit edges of the filtered clock
    next_q.scl_q = scl;
    next_q.sda_q = sda;
    if (q.scl_q && scl && q.sda_q && !sda)
    begin
      next_q.act = 1'b1;
      next_q.addr_ph = 1'b1;
      next_q.bcnt = '0;
      next_q.nack = 1'b0;
      next_q.sda_oe = 1'b0;
    end
    else if (q.scl_q && scl && !q.sda_q && sda)
    begin
      next_q.act = 1'b0;
      next_q.sda_oe = 1'b0;
    end
    else if (q.act && !q.scl_q && scl)
    begin
      if (q.bcnt < uad_pkg::BITS_BYTE)
        next_q.sh = {q.sh[6:0], sda};
      else
        next_q.nack = sda;
      next_q.bcnt = q.bcnt + 1'b1;
    end
    else if (q.act && q.scl_q && !scl)
    begin
      if (q.bcnt == uad_pkg::BITS_BYTE)
      begin
        if (q.addr_ph)
        begin
          if (q.sh[7:1] == uad_pkg::I2C_ADDR)
          begin
            next_q.sda_oe = 1'b1;
            next_q.rd = q.sh[0];
          end
          else
          begin
            next_q.act = 1'b0; // Other address: stay off the bus
          end
        end
        else
        begin
          next_q.sda_oe = !q.rd; // Master acknowledges read bytes
        end
      end
      else if (q.bcnt == uad_pkg::BITS_ACK)
      begin
        next_q.bcnt = '0;
        next_q.addr_ph = 1'b0;
        if (q.rd && !(q.nack && !q.addr_ph))
        begin
          next_q.tx = status;
          next_q.sda_oe = !status[7];
        end
        else
        begin
          next_q.sda_oe = 1'b0;
          next_q.act = q.rd ? 1'b0 : q.act;
        end
      end
      else if (q.rd && !q.addr_ph)
      begin
        next_q.sda_oe = !q.tx[3'(uad_pkg::BIT_MSB - q.bcnt)];
      end
    end

    // Line-held reset clears detection and the slave, not the line monitor
    if (q.rstp)
    begin
      next_q = '{st: uad_pkg::ST_IDLE, pre: q.pre, lowms: q.lowms, lowhit: q.lowhit,
                 irq_n: 1'b1, scl_q: scl, sda_q: sda, default: '0};
    end

    // Manual select overrides the automatic result
    next_q.fet = manual_switch_select_i ? manual_fet_i : next_q.afet;
    next_q.usb = manual_switch_select_i ? manual_usb_i : next_q.ausb;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      q <= RST;
    else
      q <= next_q;
  end

  assign fet_close_o = q.fet;
  assign usb_switch_close_o = q.usb;
  assign irq_n_out_o = q.irq_n;
  assign dev_type_o = q.dtype;
  assign dcd_timeout_o = q.dcd_to;
  assign i2c_reset_o = q.rstp;
  assign sda_o = q.sda_d;
  assign sda_oe_o = q.sda_oe;

  property p_addr;
    @(posedge mclk_i) disable iff (rst_i)
    (q.addr_ph && q.sda_oe && !$past(q.sda_oe)) |-> (q.sh[7:1] == uad_pkg::I2C_ADDR);
  endproperty
  a_addr: assert property (p_addr) else $error("acknowledged a foreign address");

  property p_lowrst;
    @(posedge mclk_i) disable iff (rst_i)
    q.rstp |-> (q.lowms == LOW_W'(uad_pkg::I2C_RST_MS)) && q.lowhit && $past(!scl && !sda);
  endproperty
  a_lowrst: assert property (p_lowrst) else $error("line reset before full hold");

  property p_sdp;
    @(posedge mclk_i) disable iff (rst_i)
    (q.afet && !$past(q.afet) && q.dtype[uad_pkg::DT_SDP]) |-> q.ausb &&
    (q.ms == MS_W'(uad_pkg::SDP_MS));
  endproperty
  a_sdp: assert property (p_sdp) else $error("standard port closed at wrong time");

  property p_chg;
    @(posedge mclk_i) disable iff (rst_i)
    (q.afet && !$past(q.afet) && (q.dtype[uad_pkg::DT_CDP] || q.dtype[uad_pkg::DT_DCP])) |->
    (q.ms == MS_W'(uad_pkg::CHG_MS));
  endproperty
  a_chg: assert property (p_chg) else $error("charging port closed at wrong time");

  property p_car;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(q.dtype[uad_pkg::DT_CAR]) |-> (q.ms == MS_W'(uad_pkg::CARKIT_MS)) && !q.afet;
  endproperty
  a_car: assert property (p_car) else $error("car kit flagged at wrong time");

  property p_idirq;
    @(posedge mclk_i) disable iff (rst_i)
    $fell(q.irq_n) |-> (q.st == uad_pkg::ST_ID_DONE) && !$past(vbus) && $past(idat) &&
    (q.idn == 2'(ID_CHECKS - 1)) && ($past(q.ms) == MS_W'(RES_MS - 1));
  endproperty
  a_idirq: assert property (p_idirq) else $error("interrupt before last check");

  property p_dcd;
    @(posedge mclk_i) disable iff (rst_i)
    $rose(q.dcd_to) |-> (q.ms == MS_W'(DCD_MS)) && $past(contact_timeout_enable_i);
  endproperty
  a_dcd: assert property (p_dcd) else $error("contact timeout misfired");

  property p_dcp;
    @(posedge mclk_i) disable iff (rst_i)
    (q.dtype[uad_pkg::DT_DCP] && !$past(manual_switch_select_i)) |-> !q.usb;
  endproperty
  a_dcp: assert property (p_dcp) else $error("USB closed on dedicated port");

  property p_man;
    @(posedge mclk_i) disable iff (rst_i)
    manual_switch_select_i |=> (q.fet == $past(manual_fet_i)) && (q.usb == $past(manual_usb_i));
  endproperty
  a_man: assert property (p_man) else $error("manual settings not applied");

endmodule : uad_core

/* uad_host.sv */
`timescale 1ns/1ns
// Serial host model: master with open-drain data and a driven clock, each clock phase lasts HP reference cycles
module uad_host #(
  parameter int HP = 12
) (
  input wire logic mclk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Idle bus: clock high, data released
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // All host changes land on falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : gap

  task automatic start();
    sda_low_o = 1'b1;
    gap(HP);
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    sda_low_o = 1'b1;
    gap(HP);
    scl_o = 1'b1;
    gap(HP);
    sda_low_o = 1'b0;
    gap(HP);
  endtask : stop

  // Data set in the low phase, line sampled at the end of the high phase
  task automatic bit_x(input logic b, input logic spike, output logic got);
    sda_low_o = ~b;
    gap(HP);
    if (spike) // One-cycle blip is shorter than the filter hold
    begin
      scl_o = 1'b1;
      gap(1);
      scl_o = 1'b0;
      gap(HP);
    end
    scl_o = 1'b1;
    gap(HP);
    got = sda_line_i;
    scl_o = 1'b0;
  endtask : bit_x

  // Byte MSB first; host releases on the ninth clock, so a read ends with a NACK
  task automatic xfer(input logic [7:0] tx, input logic spike, output logic [7:0] rx,
                      output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(tx[i], spike, g);
      rx[i] = g;
    end
    bit_x(1'b1, 1'b0, g);
    ack = ~g;
  endtask : xfer

  // Both lines low for n cycles, then released as a stop
  task automatic hold_low(input int n);
    sda_low_o = 1'b1;
    gap(HP);
    scl_o = 1'b0;
    gap(n);
    scl_o = 1'b1;
    gap(HP);
    sda_low_o = 1'b0;
    gap(HP);
  endtask : hold_low
endmodule : uad_host

/* tb.sv */
`timescale 1ns/1ns
module tb;
  localparam int C = 8;
  localparam logic [3:0] CLS [4] = '{4'h1, 4'h2, 4'h6, 4'h8};
  localparam logic [3:0] EXP [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  localparam int MS [4] = '{120, 160, 160, 140};
  logic mclk_i = 1'b0, rst_i = 1'b1, vbus = 1'b0, idp = 1'b0, contact = 1'b0;
  logic sdp = 1'b0, cdp = 1'b0, dcp = 1'b0, car = 1'b0, to_en = 1'b0;
  logic man_sel = 1'b0, man_fet = 1'b0, man_usb = 1'b0, scl, sda_low;
  logic fet, usb, irq_n, dcd_to, i2c_rst, sda_o, sda_oe, ack;
  logic [3:0] dev;
  logic [7:0] rx;
  logic [6:0] a;
  int bad_count = 0, n_checks = 0, n, rst_seen = 0;
  // Open-drain data line with pull-up
  wire sda_line = ~(sda_low | sda_oe);

  uad_core #(.CYC_PER_MS(C)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda_line), .bus_power_in_i(vbus), .accessory_id_pin_i(idp),
    .data_contact_i(contact), .port_sdp_i(sdp), .port_cdp_i(cdp), .port_dcp_i(dcp),
    .carkit_i(car), .contact_timeout_enable_i(to_en), .manual_switch_select_i(man_sel),
    .manual_fet_i(man_fet), .manual_usb_i(man_usb), .fet_close_o(fet),
    .usb_switch_close_o(usb), .irq_n_out_o(irq_n), .dev_type_o(dev),
    .dcd_timeout_o(dcd_to), .i2c_reset_o(i2c_rst), .sda_o(sda_o), .sda_oe_o(sda_oe));
  uad_host #(.HP(12)) host_u (.mclk_i(mclk_i), .sda_line_i(sda_line), .scl_o(scl),
    .sda_low_o(sda_low));

  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end

  // Counts line-held reset pulses; sampled mid-cycle, away from the launching edge
  always @(negedge mclk_i)
  begin
    if (i2c_rst === 1'b1)
      rst_seen <= rst_seen + 1;
  end

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  function automatic logic hit(input int s);
    case (s)
      0: return (|dev) === 1'b1;
      1: return dcd_to === 1'b1;
      2: return irq_n === 1'b0;
      default: return i2c_rst === 1'b1;
    endcase
  endfunction : hit

  // Latency allows for the input filter and output registers
  function automatic logic near(input int cyc, input int ms);
    return cyc >= ms * C && cyc <= ms * C + 12;
  endfunction : near

  // Bounded wait; running out ends the run
  task automatic wait_on(input int s, input int lim, output int cyc);
    cyc = 0;
    while (!hit(s) && cyc < lim)
    begin
      @(negedge mclk_i);
      cyc++;
    end
    if (cyc >= lim)
    begin
      chk(1'b0, "wait timed out");
      report_and_stop();
    end
  endtask : wait_on

  task automatic pause(input int c);
    repeat (c) @(negedge mclk_i);
  endtask : pause

  // Main sequence
  initial
  begin
    void'($urandom(98849));
    pause(4);
    rst_i = 1'b0;
    pause(1);
    chk(irq_n === 1'b1 && fet === 1'b0 && usb === 1'b0 && dev === 4'h0 && dcd_to === 1'b0 &&
        i2c_rst === 1'b0 && sda_o === 1'b0 && sda_oe === 1'b0, "reset");
    for (int k = 0; k < 4; k++)
    begin
      {car, dcp, cdp, sdp} = CLS[k];
      vbus = 1'b1;
      wait_on(0, 200 * C, n);
      chk(near(n, MS[k]), "detect time");
      pause(3);
      chk(dev === EXP[k], "device type");
      if (k < 3)
        chk(fet === 1'b1, "charger fet");
      if (k == 0)
        chk(usb === 1'b1, "usb closed");
      if (k == 2)
        chk(usb === 1'b0, "usb open on dedicated port");
      if (k == 0)
      begin
        man_sel = 1'b1;
        repeat (4)
        begin
          {man_fet, man_usb} = 2'($urandom);
          pause(3);
          chk(fet === man_fet && usb === man_usb, "manual");
        end
        man_sel = 1'b0;
        pause(3);
        chk(fet === 1'b1 && usb === 1'b1, "back to auto");
        host_u.start();
        host_u.xfer({7'h25, 1'b0}, 1'b1, rx, ack);
        chk(ack === 1'b1, "address ack with spikes");
        host_u.xfer(8'($urandom), 1'b0, rx, ack);
        chk(ack === 1'b1, "data ack");
        host_u.stop();
        repeat (3)
        begin
          a = 7'($urandom);
          if (a == 7'h25)
            a = 7'h26;
          host_u.start();
          host_u.xfer({a, 1'($urandom)}, 1'b0, rx, ack);
          chk(ack === 1'b0 && sda_oe === 1'b0, "foreign address");
          host_u.stop();
        end
        host_u.start();
        host_u.xfer({7'h25, 1'b1}, 1'b0, rx, ack);
        chk(ack === 1'b1, "read ack");
        host_u.xfer(8'hff, 1'b0, rx, ack);
        chk(rx === 8'h21, "status byte");
        host_u.stop();
        $display("test serial done");
        host_u.hold_low(20 * C);
        chk(rst_seen == 0 && dev === 4'h1, "short hold ignored");
        fork
          host_u.hold_low(40 * C);
          wait_on(3, 40 * C, n);
        join
        // Both lines are low only from the host's clock fall, one phase into the hold;
        // the millisecond prescaler phase at that moment is arbitrary
        chk(n >= 30 * C + 12 && n <= 31 * C + 24, "line reset time");
        chk(rst_seen == 1 && dev === 4'h0, "line reset once, cleared");
        $display("test line reset done");
      end
      vbus = 1'b0;
      {car, dcp, cdp, sdp} = 4'h0;
      pause(10);
      chk(dev === 4'h0 && fet === 1'b0, "cleared on bus power loss");
      $display("test class %0d done", k);
    end
    // Contact timeout enabled, then disabled
    to_en = 1'b1;
    vbus = 1'b1;
    wait_on(1, 1000 * C, n);
    chk(near(n, 600), "contact timeout");
    vbus = 1'b0;
    pause(10);
    to_en = 1'b0;
    vbus = 1'b1;
    pause(620 * C);
    chk(dcd_to === 1'b0 && dev === 4'h0, "no timeout when disabled");
    vbus = 1'b0;
    pause(10);
    // Timeout enabled but data contact seen: no timeout
    to_en = 1'b1;
    contact = 1'b1;
    vbus = 1'b1;
    pause(620 * C);
    chk(dcd_to === 1'b0 && dev === 4'h0, "no timeout with contact");
    vbus = 1'b0;
    contact = 1'b0;
    to_en = 1'b0;
    pause(10);
    $display("test contact timeout done");
    // Early detach restarts the resistor checks
    idp = 1'b1;
    pause(100 * C);
    idp = 1'b0;
    pause(10);
    chk(irq_n === 1'b1, "early detach no interrupt");
    idp = 1'b1;
    wait_on(2, 200 * C, n);
    chk(near(n, 150), "accessory interrupt time");
    idp = 1'b0;
    pause(10);
    chk(irq_n === 1'b1, "interrupt released on detach");
    $display("test accessory done");
    report_and_stop();
  end
endmodule : tb
